// ---- include/pcp_key_if.sv ----
`timescale 1ns/1ps
// ==========================================================
// Key write path between register block and key checker
// ==========================================================
interface pcp_key_if;
  logic key_wr;
  logic [7:0] key_data;
  logic commit;

  modport regs (output key_wr, output key_data, input commit);
  modport checker_side (input key_wr, input key_data, output commit);
endinterface

// ---- include/pcp_pkg.sv ----
// ==========================================================
// Shared constants for synthesizer commit and power modes
// ==========================================================
package pcp_pkg;

  // ==========================================================
  // Register addresses
  // ==========================================================
  localparam logic [31:0] PCP_ADDR_CONTROL = 32'hE01FC080;
  localparam logic [31:0] PCP_ADDR_CONFIG = 32'hE01FC084;
  localparam logic [31:0] PCP_ADDR_STATUS = 32'hE01FC088;
  localparam logic [31:0] PCP_ADDR_KEY = 32'hE01FC08C;
  localparam logic [31:0] PCP_ADDR_PMODE = 32'hE01FC0C0;
  localparam logic [31:0] PCP_ADDR_GATES = 32'hE01FC0C4;

  // ==========================================================
  // Commit key values and width
  // ==========================================================
  localparam int PCP_KEY_W = 8;
  localparam logic [7:0] PCP_KEY_FIRST = 8'hAA;
  localparam logic [7:0] PCP_KEY_SECOND = 8'h55;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int PCP_CTL_EN_BIT = 0;
  localparam int PCP_CTL_CON_BIT = 1;
  localparam int PCP_CFG_MUL_LSB = 0;
  localparam int PCP_MUL_W = 5;
  localparam int PCP_CFG_DIV_LSB = 5;
  localparam int PCP_DIV_W = 2;
  localparam int PCP_STA_EN_BIT = 8;
  localparam int PCP_STA_CON_BIT = 9;
  localparam int PCP_STA_LOCK_BIT = 10;
  localparam int PCP_PM_IDLE_BIT = 0;
  localparam int PCP_PM_DEEP_BIT = 1;

  // ==========================================================
  // Derived widths and reset values
  // ==========================================================
  localparam int PCP_MVAL_W = 6;
  localparam int PCP_PVAL_W = 4;
  localparam int PCP_CCO_W = 10;
  localparam logic [31:0] PCP_GATES_RST = 32'h0000FFBE;
  localparam logic [4:0] PCP_MUL_RST = 5'h00;
  localparam logic [1:0] PCP_DIV_RST = 2'h0;

  // Commit sequencer states
  typedef enum logic [0:0] {
    PCP_KEY_IDLE = 1'b0,
    PCP_KEY_ARMED = 1'b1
  } pcp_key_state_t;

endpackage

// ---- rtl/pcp_key_seq.sv ----
`timescale 1ns/1ps
// ==========================================================
// Two-write commit key sequencer
// ==========================================================
module pcp_key_seq
  import pcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  pcp_key_if.checker_side kif
);

  typedef struct packed {
    pcp_key_state_t st;
  } pcp_seq_t;

  pcp_seq_t s_q;
  pcp_seq_t s_d;

  // Arm on first key, commit only on second key the very next cycle
  always_comb begin
    s_d = s_q;
    kif.commit = 1'b0;
    case (s_q.st)
      PCP_KEY_IDLE: begin
        if (kif.key_wr && kif.key_data == PCP_KEY_FIRST) begin
          s_d.st = PCP_KEY_ARMED; // [RULE_01]
        end
      end
      PCP_KEY_ARMED: begin
        // Any cycle other than a first or second key drops the sequence; a first key stays armed
        if (kif.key_wr && kif.key_data == PCP_KEY_SECOND) begin
          kif.commit = 1'b1; // [RULE_01] [RULE_02]
          s_d.st = PCP_KEY_IDLE;
        end else if (kif.key_wr && kif.key_data == PCP_KEY_FIRST) begin
          s_d.st = PCP_KEY_ARMED; // [RULE_03]
        end else begin
          s_d.st = PCP_KEY_IDLE; // [RULE_03]
        end
      end
      default: begin
        s_d.st = PCP_KEY_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{st: PCP_KEY_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

endmodule // pcp_key_seq

// ---- rtl/pcp_sysctl.sv ----
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Commit needs key AA then 55
// RULE_02 - Key writes on back-to-back bus cycles
// RULE_03 - Bad key, order or gap discards commit
// RULE_04 - Key register is 8-bit write only
// RULE_05 - Deep sleep clears active enable and connect
// RULE_06 - Wakeup leaves enable and connect cleared
// RULE_07 - Software enables, waits lock, then connects
// RULE_08 - Multiplier field holds M minus one
// RULE_09 - Divider field maps to 1,2,4,8
// RULE_10 - Core clock M times oscillator; CCO 2P
// RULE_11 - Software keeps CCO in 156-320 MHz
// RULE_12 - Idle halts core, peripherals keep running
// RULE_13 - Deep sleep stops oscillator, gates clocks
// RULE_14 - Deep sleep ends on reset or wake
// RULE_15 - Wakeup resumes with no instruction lost
// RULE_16 - Writing one enters mode; deep wins
// RULE_17 - Each gate bit powers one peripheral
// RULE_18 - Synthesizer used only if enabled and connected
// RULE_19 - Idle bit 0, deep bit 1; wake clears
// RULE_20 - All pending fields commit in one cycle
module pcp_sysctl
  import pcp_pkg::*;
#(
  parameter int GATE_W = 32,
  parameter logic [31:0] GATES_RST = PCP_GATES_RST
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_sel,
  input wire logic bus_wr,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata_q,
  input wire logic synth_locked,
  input wire logic irq_wake,
  input wire logic ext_wake,
  output logic synth_enable_q,
  output logic synth_connect_q,
  output logic use_synth_q,
  output logic [PCP_MVAL_W-1:0] mult_value_q,
  output logic [PCP_PVAL_W-1:0] div_value_q,
  output logic [PCP_CCO_W-1:0] cco_ratio_q,
  output logic core_halt_q,
  output logic osc_enable_q,
  output logic clocks_gated_q,
  output logic pins_hold_q,
  output logic [GATE_W-1:0] periph_power_en_q
);

  // ==========================================================
  // State record
  // ==========================================================
  typedef struct packed {
    logic pend_en;
    logic pend_con;
    logic [PCP_MUL_W-1:0] pend_mul;
    logic [PCP_DIV_W-1:0] pend_div;
    logic act_en;
    logic act_con;
    logic [PCP_MUL_W-1:0] act_mul;
    logic [PCP_DIV_W-1:0] act_div;
    logic idle;
    logic deep;
    logic [GATE_W-1:0] gates;
    logic [31:0] rdata;
    logic use_synth;
    logic [PCP_MVAL_W-1:0] mval;
    logic [PCP_PVAL_W-1:0] pval;
    logic [PCP_CCO_W-1:0] cco;
    logic [GATE_W-1:0] pwr_en;
    logic halt;
    logic osc_en;
  } pcp_state_t;

  pcp_state_t s_q;
  pcp_state_t s_d;
  pcp_key_if kif();

  logic wr_ctl;
  logic wr_cfg;
  logic wr_key;
  logic wr_pm;
  logic wr_gates;
  logic enter_idle;
  logic enter_deep;

  // ==========================================================
  // Key sequencer
  // ==========================================================
  pcp_key_seq u_key (
    .clk(clk),
    .rst(rst),
    .kif(kif.checker_side)
  );

  // Only the low byte of a key write is looked at
  assign kif.key_wr = wr_key; // [RULE_04]
  assign kif.key_data = bus_wdata[PCP_KEY_W-1:0]; // [RULE_04]

  // ==========================================================
  // Address decode
  // ==========================================================
  assign wr_ctl = bus_sel && bus_wr && bus_addr == PCP_ADDR_CONTROL;
  assign wr_cfg = bus_sel && bus_wr && bus_addr == PCP_ADDR_CONFIG;
  assign wr_key = bus_sel && bus_wr && bus_addr == PCP_ADDR_KEY;
  assign wr_pm = bus_sel && bus_wr && bus_addr == PCP_ADDR_PMODE;
  assign wr_gates = bus_sel && bus_wr && bus_addr == PCP_ADDR_GATES;

  // Mode entry; deep sleep masks a simultaneous idle request
  assign enter_deep = wr_pm && bus_wdata[PCP_PM_DEEP_BIT]; // [RULE_16]
  assign enter_idle = wr_pm && bus_wdata[PCP_PM_IDLE_BIT]
                      && !bus_wdata[PCP_PM_DEEP_BIT]; // [RULE_16]

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    s_d = s_q;

    // Pending copies, no effect on the synthesizer yet
    if (wr_ctl) begin
      s_d.pend_en = bus_wdata[PCP_CTL_EN_BIT];
      s_d.pend_con = bus_wdata[PCP_CTL_CON_BIT];
    end
    if (wr_cfg) begin
      s_d.pend_mul = bus_wdata[PCP_CFG_MUL_LSB +: PCP_MUL_W];
      s_d.pend_div = bus_wdata[PCP_CFG_DIV_LSB +: PCP_DIV_W];
    end

    // Accepted key moves every pending field at once
    if (kif.commit) begin
      s_d.act_en = s_q.pend_en; // [RULE_01] [RULE_20]
      s_d.act_con = s_q.pend_con; // [RULE_20]
      s_d.act_mul = s_q.pend_mul; // [RULE_20]
      s_d.act_div = s_q.pend_div; // [RULE_20]
    end

    // Deep sleep forces synthesizer off and bypassed
    if (enter_deep) begin
      s_d.act_en = 1'b0; // [RULE_05]
      s_d.act_con = 1'b0; // [RULE_05]
    end

    // Idle bit: wake clears, a new entry in the same cycle wins
    if (irq_wake) begin
      s_d.idle = 1'b0; // [RULE_12] [RULE_15]
    end
    if (ext_wake) begin
      s_d.idle = 1'b0; // [RULE_12]
      s_d.deep = 1'b0; // [RULE_14] [RULE_19]
    end
    if (wr_pm) begin
      s_d.idle = enter_idle ? 1'b1 : s_d.idle; // [RULE_16] [RULE_19]
      s_d.deep = enter_deep ? 1'b1 : s_d.deep; // [RULE_16] [RULE_19]
    end
    // Wakeup touches only the mode bits, never the active copy [RULE_06]

    if (wr_gates) begin
      s_d.gates = bus_wdata[GATE_W-1:0]; // [RULE_17]
    end

    // Derived outputs from next-state values
    s_d.use_synth = s_d.act_en && s_d.act_con; // [RULE_18]
    s_d.mval = {1'b0, s_d.act_mul} + 6'h01; // [RULE_08]
    case (s_d.act_div)
      2'h0: s_d.pval = 4'h1; // [RULE_09]
      2'h1: s_d.pval = 4'h2; // [RULE_09]
      2'h2: s_d.pval = 4'h4; // [RULE_09]
      2'h3: s_d.pval = 4'h8; // [RULE_09]
      default: s_d.pval = 4'h1;
    endcase
    // CCO ratio to oscillator is M times 2 times P
    s_d.cco = (PCP_CCO_W'(s_d.mval) * PCP_CCO_W'(s_d.pval)) << 1; // [RULE_10]
    // Deep sleep gates every peripheral; idle leaves them alone
    s_d.pwr_en = s_d.deep ? '0 : s_d.gates; // [RULE_13] [RULE_17]
    // Halt and oscillator enable kept as flops of their own
    s_d.halt = s_d.idle | s_d.deep; // [RULE_12] [RULE_15]
    s_d.osc_en = !s_d.deep; // [RULE_13]

    // Read data, registered one cycle after the access
    s_d.rdata = 32'h00000000;
    if (bus_sel && !bus_wr) begin
      case (bus_addr)
        PCP_ADDR_CONTROL: begin
          s_d.rdata[PCP_CTL_EN_BIT] = s_q.pend_en;
          s_d.rdata[PCP_CTL_CON_BIT] = s_q.pend_con;
        end
        PCP_ADDR_CONFIG: begin
          s_d.rdata[PCP_CFG_MUL_LSB +: PCP_MUL_W] = s_q.pend_mul;
          s_d.rdata[PCP_CFG_DIV_LSB +: PCP_DIV_W] = s_q.pend_div;
        end
        PCP_ADDR_STATUS: begin
          s_d.rdata[PCP_CFG_MUL_LSB +: PCP_MUL_W] = s_q.act_mul;
          s_d.rdata[PCP_CFG_DIV_LSB +: PCP_DIV_W] = s_q.act_div;
          s_d.rdata[PCP_STA_EN_BIT] = s_q.act_en;
          s_d.rdata[PCP_STA_CON_BIT] = s_q.act_con;
          s_d.rdata[PCP_STA_LOCK_BIT] = synth_locked;
        end
        PCP_ADDR_PMODE: begin
          s_d.rdata[PCP_PM_IDLE_BIT] = s_q.idle;
          s_d.rdata[PCP_PM_DEEP_BIT] = s_q.deep;
        end
        PCP_ADDR_GATES: begin
          s_d.rdata[GATE_W-1:0] = s_q.gates;
        end
        default: begin
          s_d.rdata = 32'h00000000; // Key and unmapped read zero [RULE_04]
        end
      endcase
    end
  end

  // ==========================================================
  // State register; only rst loads reset values, but deep sleep entry clears act_en and act_con
  // ==========================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.pend_mul <= PCP_MUL_RST;
      s_q.pend_div <= PCP_DIV_RST;
      s_q.act_mul <= PCP_MUL_RST;
      s_q.act_div <= PCP_DIV_RST;
      s_q.mval <= 6'h01;
      s_q.pval <= 4'h1;
      s_q.cco <= 10'h002;
      s_q.gates <= GATES_RST[GATE_W-1:0];
      s_q.pwr_en <= GATES_RST[GATE_W-1:0];
      s_q.osc_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  // ==========================================================
  assign bus_rdata_q = s_q.rdata;
  assign synth_enable_q = s_q.act_en;
  assign synth_connect_q = s_q.act_con;
  assign use_synth_q = s_q.use_synth; // [RULE_18]
  assign mult_value_q = s_q.mval;
  assign div_value_q = s_q.pval;
  assign cco_ratio_q = s_q.cco; // [RULE_10]
  // Core halts in either mode, resuming at the next instruction
  assign core_halt_q = s_q.halt; // [RULE_12] [RULE_15]
  assign osc_enable_q = s_q.osc_en; // [RULE_13]
  assign clocks_gated_q = s_q.deep; // [RULE_13]
  assign pins_hold_q = s_q.deep; // [RULE_13]
  assign periph_power_en_q = s_q.pwr_en; // [RULE_17]

endmodule // pcp_sysctl

// ---- verif/pcp_sysctl_bench.sv ----
`timescale 1ns/1ps
module pcp_sysctl_bench
  import pcp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bus_sel = 1'b0, bus_wr = 1'b0, synth_locked = 1'b0;
  logic irq_wake = 1'b0, ext_wake = 1'b0;
  logic [31:0] bus_addr = '0, bus_wdata = '0, bus_rdata_q, periph_power_en_q;
  logic synth_enable_q, synth_connect_q, use_synth_q, core_halt_q;
  logic osc_enable_q, clocks_gated_q, pins_hold_q;
  logic [5:0] mult_value_q, em;
  logic [3:0] div_value_q, ep;
  logic [9:0] cco_ratio_q;
  // Settings keep 2*M*P at 32, inside the CCO band for a 10 MHz source
  logic [4:0] mt [4] = '{5'h0F, 5'h07, 5'h03, 5'h01};
  logic [7:0] ka [4] = '{8'hAB, 8'hAA, 8'h55, 8'hAA};
  logic [7:0] kb [4] = '{8'h55, 8'h56, 8'hAA, 8'h55};
  int fail_count = 0;
  int tests_run = 0;

  pcp_sysctl pcp_sysctl_i (
    .clk(clk), .rst(rst), .bus_sel(bus_sel), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
    .synth_locked(synth_locked), .irq_wake(irq_wake), .ext_wake(ext_wake),
    .synth_enable_q(synth_enable_q), .synth_connect_q(synth_connect_q),
    .use_synth_q(use_synth_q), .mult_value_q(mult_value_q),
    .div_value_q(div_value_q), .cco_ratio_q(cco_ratio_q),
    .core_halt_q(core_halt_q), .osc_enable_q(osc_enable_q),
    .clocks_gated_q(clocks_gated_q), .pins_hold_q(pins_hold_q),
    .periph_power_en_q(periph_power_en_q)
  );

  // ==========================================================
  // Bus tasks and checks
  // ==========================================================
  initial forever #50 clk = ~clk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    bus_sel = 1'b1;
    bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = d;
  endtask

  task idle;
    @(negedge clk);
    bus_sel = 1'b0;
  endtask

  task rd(input logic [31:0] a, input logic [31:0] exp);
    @(negedge clk);
    bus_sel = 1'b1;
    bus_wr = 1'b0;
    bus_addr = a;
    @(negedge clk);
    bus_sel = 1'b0;
    chk(bus_rdata_q, exp);
  endtask

  task key(input logic [7:0] a, input logic [7:0] b);
    wr(PCP_ADDR_KEY, {24'h0, a});
    wr(PCP_ADDR_KEY, {24'h0, b});
    idle;
  endtask

  // One-cycle wake pulse, external or interrupt
  task wake(input logic e);
    @(negedge clk);
    ext_wake = e;
    irq_wake = !e;
    @(negedge clk);
    ext_wake = 1'b0;
    irq_wake = 1'b0;
  endtask

  task test_done;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #1000000;
    fail_count++;
    test_done;
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(cco_ratio_q, 32'h2);
    chk(periph_power_en_q, PCP_GATES_RST);
    em = 6'h01;
    // Commit every divider code with pending check
    for (int i = 0; i < 4; i++) begin
      wr(PCP_ADDR_CONFIG, {25'h0, 2'(i), mt[i]});
      wr(PCP_ADDR_CONTROL, 32'h1);
      idle;
      chk(mult_value_q, em);
      key(8'hAA, 8'h55);
      em = mt[i] + 6'h01;
      ep = 4'h1 << i;
      chk(mult_value_q, em);
      chk(div_value_q, ep);
      chk(cco_ratio_q, 32'(em) * ep * 32'h2);
      rd(PCP_ADDR_STATUS, {21'h0, 3'h1, 1'b0, 2'(i), mt[i]});
    end
    // Broken key sequences are discarded
    wr(PCP_ADDR_CONFIG, 32'h5);
    for (int j = 0; j < 4; j++) begin
      wr(PCP_ADDR_KEY, {24'h0, ka[j]});
      if (j == 3) idle;
      key(kb[j], 8'h00);
      chk(mult_value_q, 32'h2);
    end
    wr(PCP_ADDR_KEY, 32'hAA);
    key(8'hAA, 8'h55);
    chk(mult_value_q, 32'h6);
    // Connect after lock
    synth_locked = 1'b1;
    wr(PCP_ADDR_CONTROL, 32'h3);
    key(8'hAA, 8'h55);
    chk(use_synth_q, 32'h1);
    rd(PCP_ADDR_STATUS, 32'h705);
    // Both mode bits: deep sleep, then external wake
    wr(PCP_ADDR_PMODE, 32'h3);
    idle;
    chk(synth_enable_q, 32'h0);
    chk(osc_enable_q, 32'h0);
    chk(periph_power_en_q, 32'h0);
    rd(PCP_ADDR_PMODE, 32'h2);
    wake(1'b1);
    chk(clocks_gated_q, 32'h0);
    chk(synth_enable_q, 32'h0);
    rd(PCP_ADDR_PMODE, 32'h0);
    // Idle mode, interrupt wake
    wr(PCP_ADDR_PMODE, 32'h1);
    idle;
    chk(core_halt_q, 32'h1);
    chk(periph_power_en_q, PCP_GATES_RST);
    wake(1'b0);
    chk(core_halt_q, 32'h0);
    // Gates, unmapped and key reads
    wr(PCP_ADDR_GATES, 32'h0000A5A5);
    wr(32'hE01FC0F0, 32'hFFFFFFFF);
    idle;
    chk(periph_power_en_q, 32'h0000A5A5);
    rd(PCP_ADDR_GATES, 32'h0000A5A5);
    rd(32'hE01FC0F0, 32'h0);
    rd(PCP_ADDR_KEY, 32'h0);
    test_done;
  end
endmodule // pcp_sysctl_bench

// ---- verif/pcp_sysctl_chk.sv ----
`timescale 1ns/1ps
module pcp_sysctl_chk
  import pcp_pkg::*;
#(
  parameter int GATE_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_sel,
  input wire logic bus_wr,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata_q,
  input wire logic ext_wake,
  input wire logic synth_enable_q,
  input wire logic synth_connect_q,
  input wire logic use_synth_q,
  input wire logic [PCP_MVAL_W-1:0] mult_value_q,
  input wire logic [PCP_PVAL_W-1:0] div_value_q,
  input wire logic [PCP_CCO_W-1:0] cco_ratio_q,
  input wire logic core_halt_q,
  input wire logic osc_enable_q,
  input wire logic clocks_gated_q,
  input wire logic pins_hold_q,
  input wire logic [GATE_W-1:0] periph_power_en_q
);
  // ==========================================================
  // Decoded writes
  // ==========================================================
  logic key_w;
  logic key_first_w;
  logic key_second_w;
  logic mode_w;
  // Key and mode write strobes
  assign key_w = bus_sel && bus_wr && bus_addr == PCP_ADDR_KEY;
  assign key_first_w = key_w && bus_wdata[7:0] == PCP_KEY_FIRST;
  assign key_second_w = key_w && bus_wdata[7:0] == PCP_KEY_SECOND;
  assign mode_w = bus_sel && bus_wr && bus_addr == PCP_ADDR_PMODE;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Properties
  // ==========================================================
  a_use_synth_and: assert property (
    use_synth_q == (synth_enable_q && synth_connect_q))
    else $error("use_synth differs from enable and connect");
  a_cco_ratio_two: assert property (
    cco_ratio_q == ((10'(mult_value_q) * 10'(div_value_q)) << 1))
    else $error("cco ratio is not 2*M*P");
  a_div_encoding: assert property (
    div_value_q inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("divider value outside 1,2,4,8");
  a_mult_range: assert property (
    mult_value_q inside {[6'h01:6'h20]})
    else $error("multiplier outside 1..32");
  a_commit_needs_keys: assert property (
    !$stable({mult_value_q, div_value_q}) |->
    $past(key_second_w) && $past(key_first_w, 2))
    else $error("settings changed without key pair");
  a_deep_clears_synth: assert property (
    mode_w && bus_wdata[1] |=> !synth_enable_q && !synth_connect_q
    && clocks_gated_q && core_halt_q && !osc_enable_q)
    else $error("deep sleep entry wrong");
  a_idle_only: assert property (
    mode_w && bus_wdata[1:0] == 2'h1 |=> core_halt_q && !clocks_gated_q)
    else $error("idle entry wrong");
  a_deep_pins_osc: assert property (
    osc_enable_q == !clocks_gated_q && pins_hold_q == clocks_gated_q)
    else $error("oscillator or pin hold disagrees with deep");
  a_deep_gates_off: assert property (
    clocks_gated_q |-> periph_power_en_q == '0)
    else $error("peripherals powered in deep sleep");
  a_ext_wake_ends: assert property (
    ext_wake && !mode_w |=> !clocks_gated_q && !core_halt_q)
    else $error("external wake did not end sleep");
  a_wake_no_restore: assert property (
    $fell(clocks_gated_q) |-> !synth_enable_q && !synth_connect_q)
    else $error("synth state restored on wake");
  a_read_zero_else: assert property (
    !(bus_sel && !bus_wr && bus_addr != PCP_ADDR_KEY) |=> bus_rdata_q == '0)
    else $error("read data not zero");

  // Main scenarios reached
  cover property (key_first_w ##1 key_second_w);
  cover property ($rose(clocks_gated_q));
  cover property ($fell(core_halt_q));
endmodule // pcp_sysctl_chk

bind pcp_sysctl pcp_sysctl_chk #(.GATE_W(GATE_W)) pcp_sysctl_chk_i (
  .clk(clk), .rst(rst), .bus_sel(bus_sel), .bus_wr(bus_wr),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
  .ext_wake(ext_wake), .synth_enable_q(synth_enable_q),
  .synth_connect_q(synth_connect_q), .use_synth_q(use_synth_q),
  .mult_value_q(mult_value_q), .div_value_q(div_value_q),
  .cco_ratio_q(cco_ratio_q), .core_halt_q(core_halt_q),
  .osc_enable_q(osc_enable_q), .clocks_gated_q(clocks_gated_q),
  .pins_hold_q(pins_hold_q), .periph_power_en_q(periph_power_en_q)
);
